// [lhg_cfg_pkg.sv]
// Function
// - Low-g detector triggers after (low delay field + 1) times 2.5 ms.
// - Low-g delay field resets to the value giving 20 ms.
// - Low-g threshold is field times 7.81 mg, or 3.91 mg at zero, any range.
// - Low-g threshold field resets to the value giving 375 mg.
// - High-g hysteresis is field times 125/250/500/1000 mg per g-range.
// - Low-g hysteresis is field times 125 mg for every g-range.
// - High-g detector triggers after (high delay field + 1) times 2.5 ms; reset 30 ms.
// - High-g threshold is field times 7.81/15.63/31.25/62.5 mg per g-range.
// - High-g threshold at zero field is 3.91/7.81/15.63/31.25 mg per g-range.
// - Device stays out of low power while high-g uses pre-filtered data.
// - Hysteresis byte holds high-g in bits 7:6, low-g in 1:0, 5:2 reserved.
// - Source bit selects filtered (0) or pre-filtered (1) detector data.
package lhg_cfg_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam int ADR_W = 8;
  localparam logic [7:0] IDX_LOW_DUR = 8'h5a;
  localparam logic [7:0] IDX_LOW_TH = 8'h5b;
  localparam logic [7:0] IDX_HYST = 8'h5c;
  localparam logic [7:0] IDX_HIGH_DUR = 8'h5d;
  localparam logic [7:0] IDX_HIGH_TH = 8'h5e;
  localparam logic [7:0] IDX_CTRL = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam logic [7:0] IDX_MASK = 8'h62;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_LOW_DUR = 8'h07;
  localparam logic [7:0] RST_LOW_TH = 8'h30;
  localparam logic [7:0] RST_HYST = 8'h81;
  localparam logic [7:0] RST_HIGH_DUR = 8'h0b;
  localparam logic [7:0] RST_HIGH_TH = 8'hc0;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_STS = 2'h0;
  // ==========================================================
  // Field layout
  localparam int HY_HIGH_LSB = 6;
  localparam int HY_LOW_LSB = 0;
  localparam logic [7:0] HY_KEEP_MASK = 8'hc3;
  localparam int CTRL_SRC_BIT = 0;
  localparam int STS_LOW_BIT = 0;
  localparam int STS_HIGH_BIT = 1;
  localparam int STS_W = 2;
  localparam logic SRC_FILTERED = 1'b0;
  localparam logic SRC_PREFILT = 1'b1;
  // ==========================================================
  // Range codes and magnitude scaling, one unit is 1.953 mg
  typedef enum logic [1:0] {RANGE_2G = 2'h0, RANGE_4G = 2'h1,
                            RANGE_8G = 2'h2, RANGE_16G = 2'h3} g_range_t;
  localparam int MAG_W = 14;
  localparam logic [MAG_W-1:0] THR_ZERO_UNITS = 14'h0002;
  localparam int THR_STEP_SHIFT = 2;
  localparam int HYST_STEP_SHIFT = 6;
  // ==========================================================
  // Timing
  localparam real DELAY_STEP_MS = 2.5;
  localparam real CLK_MHZ = 40.0;
  localparam int DELAY_STEP_CYCLES = int'(DELAY_STEP_MS * 1000.0 * CLK_MHZ);
endpackage : lhg_cfg_pkg

// [lhg_tick_divider.sv]
`timescale 1ns/100ps
`default_nettype none
module lhg_tick_divider
  import lhg_cfg_pkg::*;
#(
  parameter int CYCLES = DELAY_STEP_CYCLES
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Delay step enable
  output logic tick_o
);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("lhg_tick_divider: CYCLES must be at least 2");
  end
  logic [31:0] count;
  logic [31:0] next_count;
  always_comb
  begin
    next_count = count + 32'h0000_0001;
    if (count == 32'(CYCLES - 1))
    begin
      next_count = 32'h0000_0000;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= 32'h0000_0000;
      tick_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick_o <= (count == 32'(CYCLES - 1));
    end
  end
endmodule : lhg_tick_divider
`default_nettype wire

// [lhg_event_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module lhg_event_timer
  import lhg_cfg_pkg::*;
#(
  parameter int DUR_W = 8
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conditions
  input wire logic tick_i,
  input wire logic enter_i,
  input wire logic leave_i,
  input wire logic [DUR_W-1:0] dur_i,
  // Results
  output logic event_o,
  output logic active_o
);
  if (DUR_W < 1) begin : g_bad_width
    $error("lhg_event_timer: DUR_W must be at least 1");
  end
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_HELD = 2'h3} tstate_t;
  tstate_t state;
  tstate_t next_state;
  logic [DUR_W-1:0] count;
  logic [DUR_W-1:0] next_count;
  logic next_event;
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_event = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        next_count = '0;
        if (enter_i)
        begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (!enter_i)
        begin
          next_state = ST_IDLE;
        end
        else if (tick_i)
        begin
          // Fires on the (dur + 1)-th step
          if (count == dur_i)
          begin
            next_state = ST_HELD;
            next_event = 1'b1;
          end
          else
          begin
            next_count = count + 1'b1;
          end
        end
      end
      ST_HELD:
      begin
        if (leave_i)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      count <= '0;
      event_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      event_o <= next_event;
    end
  end
  assign active_o = (state == ST_HELD);
endmodule : lhg_event_timer
`default_nettype wire

// [low_high_g_interrupt_config.sv]
`timescale 1ns/100ps
`default_nettype none
module low_high_g_interrupt_config
  import lhg_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = DELAY_STEP_CYCLES
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W+1:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sensor core
  input wire logic [1:0] g_range_i,
  input wire logic [MAG_W-1:0] filt_mag_i,
  input wire logic [MAG_W-1:0] prefilt_mag_i,
  input wire logic low_power_req_i,
  // Results
  output logic low_power_en_o,
  output logic low_g_o,
  output logic high_g_o,
  output logic irq_o
);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("low_high_g_interrupt_config: TICK_CYCLES must be at least 2");
  end

  // ==========================================================
  // Scaling helpers
  function automatic logic [MAG_W:0] thr_units(input logic [7:0] field,
                                               input logic [1:0] rng);
    logic [MAG_W:0] base;
    base = {{(MAG_W-7){1'b0}}, field};
    if (field == 8'h00)
    begin
      thr_units = {1'b0, THR_ZERO_UNITS} << rng;
    end
    else
    begin
      thr_units = (base << THR_STEP_SHIFT) << rng;
    end
  endfunction : thr_units

  function automatic logic [MAG_W:0] hyst_units(input logic [1:0] field,
                                                input logic [1:0] rng);
    logic [MAG_W:0] base;
    base = {{(MAG_W-1){1'b0}}, field};
    hyst_units = (base << HYST_STEP_SHIFT) << rng;
  endfunction : hyst_units

  // ==========================================================
  // Register storage
  logic [7:0] low_dur;
  logic [7:0] low_th;
  logic [7:0] hyst;
  logic [7:0] high_dur;
  logic [7:0] high_th;
  logic [7:0] ctrl;
  logic [STS_W-1:0] status;
  logic [STS_W-1:0] mask;
  logic [7:0] next_low_dur;
  logic [7:0] next_low_th;
  logic [7:0] next_hyst;
  logic [7:0] next_high_dur;
  logic [7:0] next_high_th;
  logic [7:0] next_ctrl;
  logic [STS_W-1:0] next_status;
  logic [STS_W-1:0] next_mask;
  logic next_ack;
  logic [31:0] next_dat;
  logic next_irq;
  logic next_low_power;

  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic [STS_W-1:0] sts_set;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // ==========================================================
  // Register writes
  always_comb
  begin
    next_low_dur = low_dur;
    next_low_th = low_th;
    next_hyst = hyst;
    next_high_dur = high_dur;
    next_high_th = high_th;
    next_ctrl = ctrl;
    next_mask = mask;
    next_status = status | sts_set;
    next_ack = req;
    if (wr)
    begin
      unique case (wb_adr_i)
        IDX_LOW_DUR:
        begin
          next_low_dur = wbyte;
        end
        IDX_LOW_TH:
        begin
          next_low_th = wbyte;
        end
        IDX_HYST:
        begin
          next_hyst = wbyte & HY_KEEP_MASK;
        end
        IDX_HIGH_DUR:
        begin
          next_high_dur = wbyte;
        end
        IDX_HIGH_TH:
        begin
          next_high_th = wbyte;
        end
        IDX_CTRL:
        begin
          next_ctrl = {7'h00, wbyte[CTRL_SRC_BIT]};
        end
        IDX_STATUS:
        begin
          // Write one clears, a new event in the same cycle wins
          next_status = (status & ~wbyte[STS_W-1:0]) | sts_set;
        end
        IDX_MASK:
        begin
          next_mask = wbyte[STS_W-1:0];
        end
        default:
        begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data mux
  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        IDX_LOW_DUR:
        begin
          next_dat = {24'h000000, low_dur};
        end
        IDX_LOW_TH:
        begin
          next_dat = {24'h000000, low_th};
        end
        IDX_HYST:
        begin
          next_dat = {24'h000000, hyst & HY_KEEP_MASK};
        end
        IDX_HIGH_DUR:
        begin
          next_dat = {24'h000000, high_dur};
        end
        IDX_HIGH_TH:
        begin
          next_dat = {24'h000000, high_th};
        end
        IDX_CTRL:
        begin
          next_dat = {24'h000000, ctrl};
        end
        IDX_STATUS:
        begin
          next_dat = {30'h00000000, status};
        end
        IDX_MASK:
        begin
          next_dat = {30'h00000000, mask};
        end
        default:
        begin
          next_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_dur <= RST_LOW_DUR;
      low_th <= RST_LOW_TH;
      hyst <= RST_HYST;
      high_dur <= RST_HIGH_DUR;
      high_th <= RST_HIGH_TH;
      ctrl <= RST_CTRL;
      status <= RST_STS;
      mask <= RST_STS;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      low_dur <= next_low_dur;
      low_th <= next_low_th;
      hyst <= next_hyst;
      high_dur <= next_high_dur;
      high_th <= next_high_th;
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ==========================================================
  // Source selection and effective levels
  logic src_prefilt;
  logic [MAG_W:0] mag;
  logic [MAG_W:0] low_thr;
  logic [MAG_W:0] low_hys;
  logic [MAG_W:0] high_thr;
  logic [MAG_W:0] high_hys;
  logic [MAG_W:0] low_rel;
  logic [MAG_W:0] high_rel;

  assign src_prefilt = ctrl[CTRL_SRC_BIT];
  assign mag = (src_prefilt == SRC_PREFILT) ? {1'b0, prefilt_mag_i}
                                            : {1'b0, filt_mag_i};
  assign low_thr = thr_units(low_th, RANGE_2G);
  assign low_hys = hyst_units(hyst[HY_LOW_LSB +: 2], RANGE_2G);
  assign high_thr = thr_units(high_th, g_range_i);
  assign high_hys = hyst_units(hyst[HY_HIGH_LSB +: 2], g_range_i);
  assign low_rel = low_thr + low_hys;
  assign high_rel = (high_thr > high_hys) ? (high_thr - high_hys) : '0;

  // ==========================================================
  // Detector conditions
  logic low_enter;
  logic low_leave;
  logic high_enter;
  logic high_leave;
  logic lp_blocked;

  assign low_enter = (mag < low_thr);
  assign low_leave = (mag > low_rel);
  assign high_enter = (mag > high_thr);
  assign high_leave = (mag < high_rel);
  // Either detector on pre-filtered data keeps the core awake
  assign lp_blocked = (src_prefilt == SRC_PREFILT);

  // ==========================================================
  // Delay timers
  logic tick;
  logic low_event;
  logic high_event;

  lhg_tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  lhg_event_timer #(
    .DUR_W(8)
  ) u_low (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .enter_i(low_enter),
    .leave_i(low_leave),
    .dur_i(low_dur),
    .event_o(low_event),
    .active_o(low_g_o)
  );

  lhg_event_timer #(
    .DUR_W(8)
  ) u_high (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .enter_i(high_enter),
    .leave_i(high_leave),
    .dur_i(high_dur),
    .event_o(high_event),
    .active_o(high_g_o)
  );

  assign sts_set = {high_event, low_event};

  // ==========================================================
  // Interrupt and power outputs
  always_comb
  begin
    next_irq = |(next_status & mask);
    next_low_power = low_power_req_i && !lp_blocked;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      low_power_en_o <= 1'b0;
    end
    else
    begin
      irq_o <= next_irq;
      low_power_en_o <= next_low_power;
    end
  end
endmodule : low_high_g_interrupt_config
`default_nettype wire

// [low_high_g_interrupt_config_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module low_high_g_interrupt_config_monitor
  import lhg_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Power request and results
  input wire logic low_power_req_i,
  input wire logic low_power_en_o,
  input wire logic low_g_o,
  input wire logic high_g_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
  // ==========================================================
  // Bus handshake
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rd_width;
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read upper bits set");
  // ==========================================================
  // Power and interrupt
  property p_lp_req;
    low_power_en_o |-> $past(low_power_req_i);
  endproperty
  a_lp_req: assert property (p_lp_req) else $error("low power not asked");
  property p_reset_out;
    $fell(rst_i) |-> !low_g_o && !high_g_o && !irq_o && !low_power_en_o;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output set after reset");
  property p_irq_rise;
    $rose(irq_o) |-> low_g_o || high_g_o || $past(wr_req) || $past(wr_req, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without event");
  property p_irq_fall;
    $fell(irq_o) |-> $past(wr_req) || $past(wr_req, 2) || $past(rst_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq lost without write");
endmodule : low_high_g_interrupt_config_monitor
`default_nettype wire

// [low_high_g_interrupt_config_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module low_high_g_interrupt_config_bench
  import lhg_cfg_pkg::*;
;
  localparam int T = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] g_range_i = 2'h0;
  logic [MAG_W-1:0] filt_mag_i = 14'h00c8;
  logic [MAG_W-1:0] prefilt_mag_i = 14'h00c8;
  logic low_power_req_i = 1'b0;
  logic low_power_en_o, low_g_o, high_g_o, irq_o;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] q;
  int t;
  always #12.5 clk_i = ~clk_i;
  low_high_g_interrupt_config #(.TICK_CYCLES(T)) low_high_g_interrupt_config_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .g_range_i(g_range_i),
    .filt_mag_i(filt_mag_i), .prefilt_mag_i(prefilt_mag_i),
    .low_power_req_i(low_power_req_i), .low_power_en_o(low_power_en_o),
    .low_g_o(low_g_o), .high_g_o(high_g_o), .irq_o(irq_o));
  // ==========================================================
  // Helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    logic got;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    got = wb_ack_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (got !== 1'b1)
    begin
      n_errors++;
      final_report();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    cmp(q, {24'h0, e});
  endtask : rd
  task automatic mag(input logic [MAG_W-1:0] f, input logic [MAG_W-1:0] p);
    @(posedge clk_i);
    filt_mag_i <= f;
    prefilt_mag_i <= p;
  endtask : mag
  task automatic chk(input int n, input logic lo, input logic hi);
    repeat (n) @(posedge clk_i);
    cmp({30'h0, high_g_o, low_g_o}, {30'h0, hi, lo});
  endtask : chk
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk_i);
    cmp({31'h0, irq_o}, {31'h0, e});
  endtask : chk_irq
  // ==========================================================
  // Sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_LOW_DUR, 8'h07);
    rd(IDX_LOW_TH, 8'h30);
    rd(IDX_HYST, 8'h81);
    rd(IDX_HIGH_DUR, 8'h0b);
    rd(IDX_HIGH_TH, 8'hc0);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_STATUS, 8'h00);
    rd(IDX_MASK, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h5a + 8'(i), 8'hff);
      rd(8'h5a + 8'(i), (i == 2) ? 8'hc3 : 8'hff);
    end
    wr(8'h5f, 8'hff);
    rd(8'h5f, 8'h00);
    $display("access done");
    g_range_i <= 2'h3;
    wr(IDX_LOW_TH, 8'h10);
    wr(IDX_LOW_DUR, 8'h02);
    wr(IDX_HYST, 8'h01);
    wr(IDX_MASK, 8'h03);
    mag(14'd63, 14'd63);
    chk(2 * T - 1, 1'b0, 1'b0);
    chk(T + 4, 1'b1, 1'b0);
    chk_irq(1'b1);
    rd(IDX_STATUS, 8'h01);
    mag(14'd128, 14'd128);
    chk(3 * T, 1'b1, 1'b0);
    mag(14'd129, 14'd129);
    chk(3, 1'b0, 1'b0);
    rd(IDX_STATUS, 8'h01);
    wr(IDX_MASK, 8'h00);
    chk_irq(1'b0);
    wr(IDX_MASK, 8'h03);
    chk_irq(1'b1);
    wr(IDX_STATUS, 8'h01);
    chk_irq(1'b0);
    rd(IDX_STATUS, 8'h00);
    wr(IDX_LOW_TH, 8'h00);
    mag(14'd2, 14'd2);
    chk(3 * T + 4, 1'b0, 1'b0);
    mag(14'd1, 14'd1);
    chk(3 * T + 4, 1'b1, 1'b0);
    $display("low-g done");
    mag(14'd200, 14'd200);
    wr(IDX_HIGH_DUR, 8'h00);
    wr(IDX_HYST, 8'h00);
    mag(14'd2, 14'd2);
    for (int f = 0; f < 2; f++)
      for (int r = 0; r < 4; r++)
      begin
        wr(IDX_HIGH_TH, 8'(f));
        g_range_i <= 2'(r);
        t = (f == 1 ? 4 : 2) << r;
        mag(14'(t), 14'(t));
        chk(3 * T, 1'b0, 1'b0);
        mag(14'(t + 1), 14'(t + 1));
        chk(T + 3, 1'b0, 1'b1);
        mag(14'(t - 1), 14'(t - 1));
        chk(3, 1'b0, 1'b0);
      end
    wr(IDX_HYST, 8'h40);
    wr(IDX_HIGH_TH, 8'h40);
    for (int r = 0; r < 4; r++)
    begin
      g_range_i <= 2'(r);
      t = 256 << r;
      mag(14'(t + 1), 14'(t + 1));
      chk(T + 3, 1'b0, 1'b1);
      mag(14'(t - (64 << r)), 14'(t - (64 << r)));
      chk(3 * T, 1'b0, 1'b1);
      mag(14'(t - (64 << r) - 1), 14'(t - (64 << r) - 1));
      chk(3, 1'b0, 1'b0);
    end
    rd(IDX_STATUS, 8'h03);
    $display("high-g done");
    wr(IDX_CTRL, 8'h01);
    low_power_req_i <= 1'b1;
    mag(14'd3, 14'd1);
    chk(3 * T + 4, 1'b1, 1'b0);
    cmp({31'h0, low_power_en_o}, 32'h0);
    wr(IDX_CTRL, 8'h00);
    chk(3, 1'b0, 1'b0);
    cmp({31'h0, low_power_en_o}, 32'h1);
    $display("source and power done");
    final_report();
  end
endmodule : low_high_g_interrupt_config_bench
bind low_high_g_interrupt_config low_high_g_interrupt_config_monitor
  low_high_g_interrupt_config_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .low_power_req_i(low_power_req_i), .low_power_en_o(low_power_en_o),
  .low_g_o(low_g_o), .high_g_o(high_g_o), .irq_o(irq_o));
`default_nettype wire
